// >>> rtl/scc_top.v
// Smart charger control: enable, set-points, alert, bus slave
`timescale 1ns/10ps
`include "scc_regs.vh"
module scc_top #(
	parameter WIN_SEC    = `SCC_WIN_SEC,
	parameter CLK_HZ     = `SCC_CLK_HZ,
	parameter [37:0] WIN_CYCLES = WIN_SEC * CLK_HZ * 38'd1
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        charge_enable_in,
	output reg         charge_enable_out,
	output reg         charge_enable_oe,
	output reg         alert_out,
	output reg         alert_oe,
	output reg         adapter_present_output,
	input  wire        supply_divider_input,
	input  wire        adapter_above_battery,
	input  wire [2:0]  thermistor_code,
	input  wire        logic_supply_fail,
	input  wire [1:0]  current_limit_strap,
	input  wire [1:0]  voltage_limit_strap,
	input  wire        osc_set,
	input  wire        peak_current_compare,
	input  wire        reverse_current_compare,
	input  wire        overshoot_compare,
	input  wire        alert_response_ack,
	output reg  [9:0]  current_dac,
	output reg  [10:0] voltage_dac,
	output wire        high_side_drive,
	output wire        low_side_drive
);
	// Pin inputs collected for synchronising
	localparam NS = 16;
	wire [NS-1:0] raw_pins = {charge_enable_in, supply_divider_input,
		adapter_above_battery, thermistor_code, logic_supply_fail,
		current_limit_strap, voltage_limit_strap, osc_set,
		peak_current_compare, reverse_current_compare,
		overshoot_compare, alert_response_ack};
	wire [NS-1:0] s_pins; // Synchronised copies

	scc_sync #(
		.W (NS)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (raw_pins),
		.dout    (s_pins)
	);

	wire       en_line  = s_pins[15]; // Resolved wired-AND level
	wire       divider  = s_pins[14];
	wire       above    = s_pins[13];
	wire [2:0] therm    = s_pins[12:10];
	wire       vdd_fail = s_pins[9];
	wire [1:0] ilim_sel = s_pins[8:7];
	wire [1:0] vlim_sel = s_pins[6:5];
	wire       s_osc    = s_pins[4];
	wire       s_peak   = s_pins[3];
	wire       s_rev    = s_pins[2];
	wire       s_ov     = s_pins[1];
	wire       s_ara    = s_pins[0];
	reg        ara_d;   // Previous alert response level
	reg  [1:0] oe_hist; // Recent pull levels; line lags them

	// Current limit from strap setting
	function [9:0] ilim_dec;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: ilim_dec = 10'h0ff;
				2'h1: ilim_dec = 10'h1ff;
				2'h2: ilim_dec = 10'h2ff;
				default: ilim_dec = 10'h3ff;
			endcase
		end
	endfunction

	// Voltage limit from strap setting
	function [10:0] vlim_dec;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: vlim_dec = 11'h1ff;
				2'h1: vlim_dec = 11'h3ff;
				2'h2: vlim_dec = 11'h5ff;
				default: vlim_dec = 11'h7ff;
			endcase
		end
	endfunction

	wire [9:0]  cur_limit  = ilim_dec(ilim_sel);
	wire [10:0] volt_limit = vlim_dec(vlim_sel);

	// Software-visible state
	reg        inhibit;      // Charge inhibited by software
	reg [9:0]  cur_cmd;      // Clamped current command
	reg [10:0] volt_cmd;     // Clamped voltage command
	reg        cur_got;      // Current command seen in window
	reg        volt_got;     // Voltage command seen in window
	reg        paired;       // Pair loaded into converters
	reg        wake_stop;    // Wake-up current timed out
	reg        cur_or;       // Current over-range flag
	reg        volt_or;      // Voltage over-range flag
	reg        fault;        // Supply fault flag
	reg        alert_pend;   // Alert pending
	reg [3:0]  mon_prev;     // Previous monitored status
	reg [37:0] win_cnt;      // Window countdown
	reg        win_run;      // Window timing active
	reg        cur_wr;       // Current command pulse
	reg        volt_wr;      // Voltage command pulse
	reg        status_rd;    // Status read pulse
	reg [10:0] wr_value;     // Written set-point value
	reg        ctrl_wr;      // Control write pulse
	reg [31:0] wr_data;      // Captured write data
	reg        battery;      // Battery present

	// Write channel state
	reg        aw_got;
	reg        w_got;
	reg [7:0]  aw_addr;
	reg [3:0]  wr_strb;      // Write strobes taken with data

	wire dev_pull;
	wire batt_now  = (therm != `SCC_TH_OPEN);
	wire hot       = (therm == `SCC_TH_HOT);
	wire cold_ur   = (therm == `SCC_TH_UNDER) || (therm == `SCC_TH_COLD);
	wire [3:0] mon = {vdd_fail, inhibit, batt_now, divider};
	wire win_done  = win_run && (win_cnt == 38'h1);
	reg [37:0] wake_cnt;     // Idle time since power and battery
	wire wake_timer_done = (wake_cnt == WIN_CYCLES[37:0]);

	// Charging blocked by battery, supply, heat or software
	wire block = !batt_now || !divider || hot || inhibit;
	assign dev_pull = block || (!paired && wake_stop);

	// Write address and data, taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= 8'h00;
			wr_data       <= 32'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			cur_wr        <= 1'b0;
			volt_wr       <= 1'b0;
			ctrl_wr       <= 1'b0;
			wr_value      <= 11'h0;
		end
		else
		begin
			cur_wr        <= 1'b0;
			volt_wr       <= 1'b0;
			ctrl_wr       <= 1'b0;
			s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_got && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got   <= 1'b1;
				wr_data <= s_axi_wdata;
			end
			// Both halves present: perform write, respond
			if (aw_got && w_got && !s_axi_bvalid)
			begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				wr_value     <= wr_data[10:0];
				// Decode by address
				if (aw_addr == `SCC_OFF_CTRL)
					ctrl_wr <= wr_strb[0];
				else if (aw_addr == `SCC_OFF_ISET)
					cur_wr <= 1'b1;
				else if (aw_addr == `SCC_OFF_VSET)
					volt_wr <= 1'b1;
				else if (aw_addr == `SCC_OFF_STATUS ||
					aw_addr == `SCC_OFF_STRAP ||
					aw_addr == `SCC_OFF_ALERT ||
					aw_addr == `SCC_OFF_ADDR)
					s_axi_bresp <= 2'h0; // Read-only, ignored
				else
					s_axi_bresp <= 2'h2; // Unmapped: slave error
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Byte strobes of all four lanes captured with data
	always @(posedge aclk)
	begin
		if (!aresetn)
			wr_strb <= 4'h0;
		else if (s_axi_wvalid && s_axi_wready)
			wr_strb <= s_axi_wstrb;
	end

	// Read channel: one cycle to data
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
			status_rd     <= 1'b0;
		end
		else
		begin
			status_rd     <= 1'b0;
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				s_axi_rdata  <= 32'h0;
				if (s_axi_araddr == `SCC_OFF_CTRL)
					s_axi_rdata[`SCC_CTRL_INHIBIT] <= inhibit;
				else if (s_axi_araddr == `SCC_OFF_STATUS)
				begin
					s_axi_rdata[9:0] <= {wake_stop, paired,
						!charge_enable_oe, !batt_now, volt_or,
						cur_or, fault, inhibit, batt_now, divider};
					status_rd <= 1'b1;
				end
				else if (s_axi_araddr == `SCC_OFF_ISET)
					s_axi_rdata[9:0] <= current_dac;
				else if (s_axi_araddr == `SCC_OFF_VSET)
					s_axi_rdata[10:0] <= voltage_dac;
				else if (s_axi_araddr == `SCC_OFF_STRAP)
					s_axi_rdata[26:0] <= {volt_limit, 6'h0, cur_limit};
				else if (s_axi_araddr == `SCC_OFF_ALERT)
					s_axi_rdata[0] <= alert_pend;
				else if (s_axi_araddr == `SCC_OFF_ADDR)
					s_axi_rdata[6:0] <= `SCC_BUS_ADDR;
				else
					s_axi_rresp <= 2'h2;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Set-point capture, clamp and pairing window
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			inhibit   <= 1'b0;
			cur_cmd   <= 10'h0;
			volt_cmd  <= 11'h0;
			cur_got   <= 1'b0;
			volt_got  <= 1'b0;
			paired    <= 1'b0;
			wake_stop <= 1'b0;
			cur_or    <= 1'b0;
			volt_or   <= 1'b0;
			win_cnt   <= 38'h0;
			win_run   <= 1'b0;
			battery   <= 1'b0;
		end
		else
		begin
			battery <= batt_now;
			// Reinsertion clears inhibit and re-arms wake-up
			if (batt_now && !battery)
			begin
				inhibit   <= 1'b0;
				wake_stop <= 1'b0;
				paired    <= 1'b0;
			end
			else if (ctrl_wr)
				inhibit <= wr_data[`SCC_CTRL_INHIBIT];
			if (ctrl_wr && wr_data[`SCC_CTRL_ZERO])
			begin
				cur_cmd  <= 10'h0;
				volt_cmd <= 11'h0;
				paired   <= 1'b0;
			end
			if (cur_wr)
			begin
				// Clamp to strap limit over the low half-word
				if (wr_data[15:0] > {6'h0, cur_limit})
				begin
					cur_cmd <= cur_limit;
					cur_or  <= 1'b1;
				end
				else
				begin
					cur_cmd <= wr_value[9:0];
					cur_or  <= 1'b0;
				end
			end
			if (volt_wr)
			begin
				if (wr_data[15:0] > {5'h0, volt_limit})
				begin
					volt_cmd <= volt_limit;
					volt_or  <= 1'b1;
				end
				else
				begin
					volt_cmd <= wr_value;
					volt_or  <= 1'b0;
				end
			end
			// Window restarts on every valid command
			if (cur_wr || volt_wr)
			begin
				win_cnt <= WIN_CYCLES[37:0];
				win_run <= 1'b1;
				if ((cur_wr || cur_got) && (volt_wr || volt_got))
				begin
					paired   <= 1'b1;
					cur_got  <= 1'b0;
					volt_got <= 1'b0;
				end
				else
				begin
					cur_got  <= cur_got || cur_wr;
					volt_got <= volt_got || volt_wr;
				end
			end
			else if (win_run)
			begin
				win_cnt <= win_cnt - 38'h1;
				if (win_done)
				begin
					win_run  <= 1'b0;
					cur_got  <= 1'b0;
					volt_got <= 1'b0;
				end
			end
			// Wake-up ends after idle window when cold or under-range
			if (!paired && cold_ur && (win_done || !win_run) &&
				wake_timer_done)
				wake_stop <= 1'b1;
		end
	end

	// Wake-up timer counts from battery and adapter presence
	always @(posedge aclk)
	begin
		if (!aresetn)
			wake_cnt <= 38'h0;
		else if (!batt_now || !divider || cur_wr || volt_wr || paired)
			wake_cnt <= 38'h0;
		else if (!wake_timer_done)
			wake_cnt <= wake_cnt + 38'h1;
	end

	// Converter codes: wake-up until a pair is loaded
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			current_dac <= 10'h0;
			voltage_dac <= 11'h0;
		end
		else if (paired)
		begin
			current_dac <= cur_cmd;
			voltage_dac <= volt_cmd;
		end
		else if (!block && !wake_stop)
		begin
			current_dac <= `SCC_WAKE_CODE;
			voltage_dac <= volt_limit;
		end
		else
		begin
			current_dac <= 10'h0;
			voltage_dac <= 11'h0;
		end
	end

	// Pins, fault and alert
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			charge_enable_out      <= 1'b0;
			charge_enable_oe       <= 1'b1;
			adapter_present_output <= 1'b0;
			fault                  <= 1'b0;
			alert_pend             <= 1'b0;
			alert_out              <= 1'b0;
			alert_oe               <= 1'b0;
			mon_prev               <= 4'h0;
			ara_d                  <= 1'b0;
			oe_hist                <= 2'h3;
		end
		else
		begin
			ara_d                  <= s_ara;
			oe_hist                <= {oe_hist[0], charge_enable_oe};
			charge_enable_out      <= 1'b0;
			charge_enable_oe       <= dev_pull;
			adapter_present_output <= divider;
			mon_prev               <= mon;
			// Line lags our own release by the synchroniser: mask it
			fault <= (!en_line && !charge_enable_oe && !(|oe_hist))
				|| !above;
			// Change sets alert; set wins over release
			if (mon != mon_prev)
				alert_pend <= 1'b1;
			else if (status_rd || (s_ara && !ara_d))
				alert_pend <= 1'b0;
			alert_out <= 1'b0;
			alert_oe  <= alert_pend;
		end
	end

	scc_gate u_gate (
		.aclk            (aclk),
		.aresetn         (aresetn),
		.run             (en_line && paired),
		.osc_set         (s_osc),
		.peak_trip       (s_peak),
		.reverse_trip    (s_rev),
		.overshoot       (s_ov),
		.high_side_drive (high_side_drive),
		.low_side_drive  (low_side_drive)
	);
endmodule // scc_top

// >>> rtl/scc_regs.vh
// Constants shared by the charger control logic
//
// Function
// - Charge enable is wired-AND, any party pulls low
// - Outside pull-low on enable sets supply fault
// - Adapter not above battery sets supply fault
// - Open-drain active-low alert output to host
// - Adapter-present output follows supply divider comparator
// - Open thermistor code disables charging
// - Low divider or hot code disables charging
// - Wake-up current before any set-point commands
// - Cold or under-range stops wake-up after window
// - Both commands in window load converters, enable
// - Clamp set-points to limits, flag over-range
// - Current code 10 bits, voltage code 11 bits
// - Alert on adapter, battery, inhibit, supply-fail change
// - Status read or alert response releases alert
// - Cycle latch set turns high side on, peak resets
// - Low side on until reverse trip or next cycle
// - Overshoot holds high side off until clear
// - Limits decoded digitally from strap settings
// - Command-pair window nominal 175 s, 140 to 210
// - Bus target address 0x12
`ifndef SCC_REGS_VH
`define SCC_REGS_VH

// Register byte offsets
`define SCC_OFF_CTRL     8'h00
`define SCC_OFF_STATUS   8'h04
`define SCC_OFF_ISET     8'h08
`define SCC_OFF_VSET     8'h0c
`define SCC_OFF_STRAP    8'h10
`define SCC_OFF_ALERT    8'h14
`define SCC_OFF_ADDR     8'h18

// Control fields
`define SCC_CTRL_INHIBIT 0
`define SCC_CTRL_ZERO    1

// Status fields
`define SCC_ST_ADAPTER   0
`define SCC_ST_BATTERY   1
`define SCC_ST_INHIBIT   2
`define SCC_ST_FAULT     3
`define SCC_ST_CUR_OR    4
`define SCC_ST_VOLT_OR   5
`define SCC_ST_OPEN      6
`define SCC_ST_ENABLE    7
`define SCC_ST_PAIRED    8
`define SCC_ST_WAKE      9

// Thermistor decoder codes
`define SCC_TH_OPEN      3'h0
`define SCC_TH_HOT       3'h1
`define SCC_TH_UNDER     3'h2
`define SCC_TH_COLD      3'h3
`define SCC_TH_IDEAL     3'h4

// Wake-up current code and target address
`define SCC_WAKE_CODE    10'h050
`define SCC_BUS_ADDR     7'h12

// Window timing: seconds and clock rate
`define SCC_WIN_SEC      175
`define SCC_CLK_HZ       50000000

`endif

// >>> rtl/scc_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module scc_sync #(
	parameter W = 8
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] stage; // First stage, read only by second

	// Two stages before any logic looks at a pin
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stage <= {W{1'b0}};
			dout  <= {W{1'b0}};
		end
		else
		begin
			stage <= din;
			dout  <= stage;
		end
	end
endmodule // scc_sync

// >>> rtl/scc_gate.v
// Buck switch sequencing for high-side and low-side drives
`timescale 1ns/10ps
module scc_gate (
	input  wire aclk,
	input  wire aresetn,
	input  wire run,
	input  wire osc_set,
	input  wire peak_trip,
	input  wire reverse_trip,
	input  wire overshoot,
	output reg  high_side_drive,
	output reg  low_side_drive
);
	reg cycle_latch; // Cycle latch, set by oscillator

	// Latch set per cycle, reset by peak compare
	always @(posedge aclk)
	begin
		if (!aresetn)
			cycle_latch <= 1'b0;
		else if (!run || overshoot)
			cycle_latch <= 1'b0;
		else if (osc_set)
			cycle_latch <= 1'b1;
		else if (peak_trip)
			cycle_latch <= 1'b0;
	end

	// Drives never overlap; low side ends on reverse trip
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			high_side_drive <= 1'b0;
			low_side_drive  <= 1'b0;
		end
		else
		begin
			high_side_drive <= cycle_latch && run && !overshoot;
			if (!run)
				low_side_drive <= 1'b0;
			else if (cycle_latch || osc_set || reverse_trip)
				low_side_drive <= 1'b0;
			else if (high_side_drive)
				low_side_drive <= 1'b1;
		end
	end
endmodule // scc_gate

// >>> sim/scc_pin_model.sv
// Wired lines outside the charger: enable bus and alert pull-up
`timescale 1ns/10ps
module scc_pin_model (
	input  wire charge_enable_oe,
	input  wire alert_oe,
	input  wire ext_pull_low,
	output wire charge_enable_line,
	output wire alert_line_n
);
	// Pull-up wins only while no party pulls the line low
	assign charge_enable_line = !(charge_enable_oe || ext_pull_low);
	// Weak pull-up on the alert line when the charger lets go
	assign alert_line_n = !alert_oe;
endmodule // scc_pin_model

// >>> sim/scc_top_assertions.sv
// Port-level checks for the charger control block
`timescale 1ns/10ps
`include "scc_regs.vh"
module scc_top_assertions (
	input wire       aclk,
	input wire       aresetn,
	input wire [7:0] s_axi_araddr,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	input wire       s_axi_rready,
	input wire       charge_enable_out,
	input wire       charge_enable_oe,
	input wire       alert_out,
	input wire       alert_oe,
	input wire       adapter_present_output,
	input wire       supply_divider_input,
	input wire [2:0] thermistor_code,
	input wire       reverse_current_compare,
	input wire       overshoot_compare,
	input wire       high_side_drive,
	input wire       low_side_drive
);
	reg [7:0] rd_addr; // Target of the read in flight
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Remember the address so the answer can be tied to it
	always @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready)
			rd_addr <= s_axi_araddr;
	a_drive_lows: assert property (!charge_enable_out && !alert_out)
		else $error("open-drain data not low");
	a_adapter_high: assert property (supply_divider_input [*4]
		|-> adapter_present_output) else $error("adapter flag stuck low");
	a_adapter_low: assert property (!supply_divider_input [*4]
		|-> !adapter_present_output) else $error("adapter flag stuck high");
	a_open_pulls: assert property ((thermistor_code == `SCC_TH_OPEN) [*5]
		|-> charge_enable_oe) else $error("enable free without battery");
	a_hot_or_low: assert property ((!supply_divider_input
		|| thermistor_code == `SCC_TH_HOT) [*5] |-> charge_enable_oe)
		else $error("enable free while hot or unpowered");
	a_alert_change: assert property ($changed(supply_divider_input)
		|-> ##[1:6] alert_oe) else $error("no alert on adapter change");
	a_alert_release: assert property (s_axi_rvalid && s_axi_rready
		&& rd_addr == `SCC_OFF_STATUS |-> ##[1:3] !alert_oe)
		else $error("alert kept after status read");
	a_overshoot_off: assert property (overshoot_compare [*4]
		|-> !high_side_drive) else $error("high side on in overshoot");
	a_reverse_off: assert property (reverse_current_compare [*4]
		|-> !low_side_drive) else $error("low side on after reverse trip");
	a_no_overlap: assert property (!(high_side_drive && low_side_drive))
		else $error("both switch drives on");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
endmodule // scc_top_assertions
bind scc_top scc_top_assertions u_chk (.*);

// >>> sim/testbench.sv
// Self-checking bench for the charger control block
`timescale 1ns/10ps
`include "scc_regs.vh"
module testbench;
	reg         aclk = 1'b0, aresetn = 1'b0, osc_set = 1'b0;
	reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	reg         s_axi_rready = 1'b0, ext_pull_low = 1'b0;
	reg         supply_divider_input = 1'b1, adapter_above_battery = 1'b1;
	reg  [2:0]  thermistor_code = `SCC_TH_IDEAL;
	reg         logic_supply_fail = 1'b0, alert_response_ack = 1'b0;
	reg  [1:0]  current_limit_strap = 2'h0, voltage_limit_strap = 2'h0;
	reg         peak_current_compare = 1'b0, reverse_current_compare = 1'b0;
	reg         overshoot_compare = 1'b0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire        s_axi_rvalid, charge_enable_in, charge_enable_out;
	wire        charge_enable_oe, alert_out, alert_oe, alert_line_n;
	wire        adapter_present_output, high_side_drive, low_side_drive;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [9:0]  current_dac;
	wire [10:0] voltage_dac;
	logic [31:0] rd_data; // Last read word
	logic [1:0]  rd_resp; // Last read response
	logic [1:0]  wr_resp; // Last write response
	int          error_cnt = 0, compares = 0, i;
	// System clock and free-running oscillator on its own phase
	always #10 aclk = ~aclk;
	always #80 osc_set = ~osc_set;
	// Short window keeps the pairing tests brief
	scc_top #(.WIN_CYCLES(100)) dut (.*);
	scc_pin_model u_pins (.charge_enable_oe(charge_enable_oe),
		.alert_oe(alert_oe), .ext_pull_low(ext_pull_low),
		.charge_enable_line(charge_enable_in), .alert_line_n(alert_line_n));
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, g);
		chk_word(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic timeout(input string nm);
		error_cnt++;
		$display("mismatch %s expected answer seen timeout", nm);
		test_done;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Both write halves offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		wr_resp = s_axi_bresp;
		if (!s_axi_bvalid)
			timeout("write");
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid && n < 50);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (!s_axi_rvalid)
			timeout("read");
		@(posedge aclk);
	endtask
	task automatic st_bit(input int b, input logic e, input string nm);
		axi_rd(`SCC_OFF_STATUS);
		chk_bit(nm, e, rd_data[b]);
	endtask
	// Bounded wait for a switch drive to reach a level
	task automatic wait_drv(input bit hi, input logic v, input string nm);
		int n;
		n = 0;
		while ((hi ? high_side_drive : low_side_drive) !== v && n < 20)
		begin
			@(posedge aclk);
			n++;
		end
		chk_bit(nm, v, hi ? high_side_drive : low_side_drive);
	endtask
	task automatic do_reset(input logic [2:0] code);
		aresetn <= 1'b0;
		thermistor_code <= code;
		cyc(10);
		aresetn <= 1'b1;
		cyc(4);
	endtask
	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask
	initial
	begin
		do_reset(`SCC_TH_IDEAL);
		axi_rd(`SCC_OFF_ADDR);
		chk_word("bus address", 32'h12, rd_data);
		axi_rd(8'h1c);
		chk_word("unmapped resp", 32'h2, {30'h0, rd_resp});
		axi_wr(8'h1c, 32'h0);
		chk_word("unmapped wr", 32'h2, {30'h0, wr_resp});
		chk_word("wake code", 32'h050, {22'h0, current_dac});
		chk_bit("adapter out", 1'b1, adapter_present_output);
		end_test("map");
		// Every strap setting, commands at the top of the range
		for (i = 0; i < 4; i++)
		begin
			current_limit_strap <= i[1:0];
			voltage_limit_strap <= i[1:0];
			cyc(4);
			axi_wr(`SCC_OFF_ISET, 32'h3ff);
			axi_wr(`SCC_OFF_VSET, 32'h7ff);
			cyc(3);
			chk_word("cur code", {i[1:0], 8'hff}, current_dac);
			chk_word("volt code", {i[1:0], 9'h1ff}, voltage_dac);
			axi_rd(`SCC_OFF_STATUS);
			chk_bit("cur over", i != 3, rd_data[`SCC_ST_CUR_OR]);
			chk_bit("volt over", i != 3, rd_data[`SCC_ST_VOLT_OR]);
			axi_rd(`SCC_OFF_STRAP);
			chk_word("limits", {i[1:0], 9'h1ff, 6'h0, i[1:0], 8'hff}, rd_data);
		end
		axi_wr(`SCC_OFF_ISET, 32'h123);
		axi_wr(`SCC_OFF_VSET, 32'h456);
		cyc(6);
		chk_word("cur code", 32'h123, current_dac);
		chk_word("volt code", 32'h456, voltage_dac);
		chk_bit("enable free", 1'b0, charge_enable_oe);
		chk_bit("enable line", 1'b1, charge_enable_in);
		axi_wr(`SCC_OFF_CTRL, 32'h1);
		cyc(3);
		chk_bit("inhibit pulls", 1'b1, charge_enable_oe);
		chk_bit("alert raised", 1'b1, alert_oe);
		st_bit(`SCC_ST_INHIBIT, 1'b1, "inhibit flag");
		axi_wr(`SCC_OFF_CTRL, 32'h0);
		cyc(6);
		end_test("setpoints");
		wait_drv(1, 1'b1, "high on");
		peak_current_compare <= 1'b1;
		wait_drv(1, 1'b0, "high off");
		wait_drv(0, 1'b1, "low on");
		reverse_current_compare <= 1'b1;
		wait_drv(0, 1'b0, "low off");
		cyc(4);
		peak_current_compare <= 1'b0;
		reverse_current_compare <= 1'b0;
		overshoot_compare <= 1'b1;
		cyc(20);
		chk_bit("high held off", 1'b0, high_side_drive);
		overshoot_compare <= 1'b0;
		wait_drv(1, 1'b1, "high resumes");
		end_test("switching");
		ext_pull_low <= 1'b1;
		cyc(6);
		st_bit(`SCC_ST_FAULT, 1'b1, "fault by line");
		ext_pull_low <= 1'b0;
		adapter_above_battery <= 1'b0;
		cyc(6);
		st_bit(`SCC_ST_FAULT, 1'b1, "fault by adapter");
		adapter_above_battery <= 1'b1;
		cyc(4);
		thermistor_code <= `SCC_TH_OPEN;
		cyc(6);
		chk_bit("alert raised", 1'b1, alert_oe);
		chk_bit("alert pin", 1'b0, alert_line_n);
		chk_bit("open pulls", 1'b1, charge_enable_oe);
		st_bit(`SCC_ST_OPEN, 1'b1, "open flag");
		cyc(3);
		chk_bit("alert by read", 1'b0, alert_oe);
		thermistor_code <= `SCC_TH_HOT;
		cyc(6);
		chk_bit("alert raised", 1'b1, alert_oe);
		chk_bit("hot pulls", 1'b1, charge_enable_oe);
		alert_response_ack <= 1'b1;
		cyc(1);
		alert_response_ack <= 1'b0;
		cyc(4);
		chk_bit("alert by ack", 1'b0, alert_oe);
		logic_supply_fail <= 1'b1;
		cyc(6);
		chk_bit("alert on supply", 1'b1, alert_oe);
		st_bit(`SCC_ST_FAULT, 1'b0, "no fault");
		logic_supply_fail <= 1'b0;
		thermistor_code <= `SCC_TH_IDEAL;
		supply_divider_input <= 1'b0;
		cyc(6);
		chk_bit("adapter out", 1'b0, adapter_present_output);
		chk_bit("low pulls", 1'b1, charge_enable_oe);
		chk_bit("alert raised", 1'b1, alert_oe);
		supply_divider_input <= 1'b1;
		end_test("status");
		// Cold pack with no commands: wake current ends with the window
		do_reset(`SCC_TH_COLD);
		st_bit(`SCC_ST_WAKE, 1'b0, "wake running");
		chk_word("wake code", 32'h050, current_dac);
		cyc(120);
		st_bit(`SCC_ST_WAKE, 1'b1, "wake stopped");
		end_test("wake");
		// Pair spans more than one window, saved by the restart
		do_reset(`SCC_TH_IDEAL);
		axi_wr(`SCC_OFF_ISET, 32'h080);
		cyc(70);
		axi_wr(`SCC_OFF_ISET, 32'h080);
		cyc(70);
		axi_wr(`SCC_OFF_VSET, 32'h100);
		cyc(3);
		st_bit(`SCC_ST_PAIRED, 1'b1, "paired");
		chk_word("cur code", 32'h080, current_dac);
		axi_wr(`SCC_OFF_CTRL, 32'h2);
		cyc(3);
		chk_word("zeroed", 32'h050, current_dac);
		end_test("window");
		test_done;
	end
endmodule // testbench
